// ===== sfd_decoder.sv
/*
 * Instruction decoder and write protection of a small serial flash.
 * Frames instructions on select, decodes opcodes, keeps the status
 * byte, streams read data and identification, and hands program and
 * erase jobs to array logic on the same clock that answers JOB_DONE.
 */
// Function
// - 4M variant protects top 1/8, 1/4, 1/2, or all when top bit set.
// - 2M variant ignores top bit; 01, 10, 11 protect quarter, half, all.
// - 1M variant protects everything only when mid and low bits are set.
// - Select falling starts an instruction; first byte is the opcode.
// - Input bits arrive MSB first, sampled on rising serial clock.
// - Reads end on select high after any bit.
// - Write-type instructions run only if select rises on a byte boundary.
// - While busy, every instruction but status read is ignored.
// - Decode read, fast read with dummy, and page program with data.
// - Decode sector erase, chip erase, power-down and status write.
// - Opcode 06h sets the write latch.
// - Program, erase and status write need the write latch set.
// - Opcode 04h clears the write latch.
// - Write latch clears at reset and when a job completes.
// - Opcode 05h shifts the status byte out MSB first on falling edges.
// - Status read is accepted while busy, but is ignored in power-down.
// - Status byte repeats every eight clocks until select rises.
// - ABh plus three dummies leaves power-down and repeats part code.
// - 90h plus three bytes returns maker and part codes alternately.
// - Status bits: busy 0, latch 1, protect 4..2, lock 7.
// - Status bits 5 and 6 always read zero.
// - Lock bit set with guard pin low rejects status writes.
// - Program or sector erase into a protected range is not run.
`timescale 1ns/1ns
module sfd_decoder (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Serial link pins
	input wire logic SPI_CS_N,
	input wire logic SPI_SCK,
	input wire logic SERIAL_IN,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_OE,
	// Protection and variant
	input wire logic WRITE_GUARD_N,
	input wire logic [1:0] DENSITY_SEL,
	// Array job handshake
	output logic JOB_START,
	output logic [1:0] JOB_KIND,
	output logic [23:0] JOB_ADDR,
	input wire logic JOB_DONE,
	// Page data staging
	output logic DATA_STROBE,
	output logic [7:0] DATA_BYTE,
	output logic [23:0] DATA_ADDR,
	// Array read
	output logic [23:0] READ_ADDR,
	input wire logic [7:0] ARRAY_RDATA,
	// Status
	output logic [7:0] STATUS_BYTE,
	output logic POWERED_DOWN
);
	import sfd_pkg::*;

	typedef enum logic [2:0] {
		ST_OPC = 3'b000,
		ST_ADDR = 3'b001,
		ST_DUMMY = 3'b010,
		ST_OUT = 3'b011,
		ST_PROG = 3'b100,
		ST_STAT = 3'b101,
		ST_WAIT = 3'b110,
		ST_SKIP = 3'b111
	} sfd_state_e;

	sfd_link_if lnk();

	sfd_state_e state_r;
	logic [2:0] bit_cnt_r;
	logic [7:0] shin_r;
	logic [7:0] opc_r;
	logic [1:0] cnt_r;
	logic [23:0] addr_r;
	logic data_seen_r;
	logic [7:0] new_stat_r;
	logic busy_r;
	logic wel_r;
	logic [2:0] bp_r;
	logic lock_r;
	logic pd_r;
	logic [2:0] out_cnt_r;
	logic [7:0] osh_r;
	logic id_sel_r;
	logic [7:0] in_byte;
	logic byte_done;
	logic fetch;
	logic commit;
	logic [7:0] status;
	logic [7:0] part_code;
	logic [7:0] out_src;
	logic [7:0] out_nxt;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] bp,
			input logic [1:0] dens);
		logic hit;
		hit = 1'b0;
		case (dens)
			DENS_4M: begin
				if (bp[2]) begin
					hit = (a <= P4_TOP);
				end else begin
					case (bp[1:0])
						2'b01: hit = (a >= P4_EIGHTH) && (a <= P4_TOP);
						2'b10: hit = (a >= P4_QUARTER) && (a <= P4_TOP);
						2'b11: hit = (a >= P4_HALF) && (a <= P4_TOP);
						default: hit = 1'b0;
					endcase
				end
			end
			DENS_2M: begin
				case (bp[1:0])
					2'b01: hit = (a >= P2_QUARTER) && (a <= P2_TOP);
					2'b10: hit = (a >= P2_HALF) && (a <= P2_TOP);
					2'b11: hit = (a <= P2_TOP);
					default: hit = 1'b0;
				endcase
			end
			default: begin
				hit = bp[1] && bp[0] && (a <= P1_TOP);
			end
		endcase
		return hit;
	endfunction : prot_hit

	function automatic logic prot_any(input logic [2:0] bp, input logic [1:0] dens);
		logic any;
		case (dens)
			DENS_4M: any = (bp != 3'h0);
			DENS_2M: any = (bp[1:0] != 2'h0);
			default: any = bp[1] && bp[0];
		endcase
		return any;
	endfunction : prot_any

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	sfd_link_sync u_sync (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.cs_n_pin(SPI_CS_N),
		.sck_pin(SPI_SCK),
		.si_pin(SERIAL_IN),
		.guard_n_pin(WRITE_GUARD_N),
		.lnk(lnk.src)
	);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	assign in_byte = {shin_r[6:0], lnk.si};
	assign byte_done = lnk.sck_rise && (bit_cnt_r == 3'h7);
	assign fetch = lnk.sck_fall && (state_r == ST_OUT) && (out_cnt_r == 3'h0);
	assign commit = lnk.cs_rise && (bit_cnt_r == 3'h0);
	assign status = {lock_r, 2'b00, bp_r, wel_r, busy_r};

	always_comb begin
		case (DENSITY_SEL)
			DENS_4M: part_code = PART_CODE_4M;
			DENS_2M: part_code = PART_CODE_2M;
			default: part_code = PART_CODE_1M;
		endcase
	end

	always_comb begin
		case (opc_r)
			OP_READ, OP_FREAD: out_src = ARRAY_RDATA;
			OP_RELPD: out_src = part_code;
			OP_MFID: out_src = id_sel_r ? part_code : MAKER_CODE;
			default: out_src = status;
		endcase
	end

	// ****************************************************************
	// Bit framing
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N || !lnk.cs_act) begin
			bit_cnt_r <= 3'h0;
			shin_r <= 8'h00;
		end else if (lnk.sck_rise) begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shin_r <= in_byte;
		end
	end

	// ****************************************************************
	// Instruction decoder
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N || !lnk.cs_act) begin
			state_r <= ST_OPC;
			cnt_r <= 2'h0;
			data_seen_r <= 1'b0;
			if (!RST_N) begin
				opc_r <= 8'h00;
				addr_r <= 24'h00_0000;
				new_stat_r <= ST_RESET;
			end
		end else if (byte_done) begin
			case (state_r)
				ST_OPC: begin
					opc_r <= in_byte;
					if (busy_r && in_byte != OP_RDSR) begin
						state_r <= ST_SKIP;
					end else if (pd_r && in_byte != OP_RELPD) begin
						state_r <= ST_SKIP;
					end else begin
						case (in_byte)
							OP_READ, OP_FREAD, OP_PROG, OP_SERASE: begin
								state_r <= ST_ADDR;
								cnt_r <= ADDR_BYTES_LEFT;
							end
							OP_RDSR: state_r <= ST_OUT;
							OP_WRSR: state_r <= ST_STAT;
							OP_WREN, OP_WRDI, OP_CERASE, OP_PDOWN: state_r <= ST_WAIT;
							OP_RELPD, OP_MFID: begin
								state_r <= ST_DUMMY;
								cnt_r <= DUMMY_BYTES_LEFT;
							end
							default: state_r <= ST_SKIP;
						endcase
					end
				end
				ST_ADDR: begin
					addr_r <= {addr_r[15:0], in_byte};
					cnt_r <= cnt_r - 2'h1;
					if (cnt_r == 2'h0) begin
						case (opc_r)
							OP_READ: state_r <= ST_OUT;
							OP_FREAD: begin
								// One dummy byte only, not the three of the id reads
								state_r <= ST_DUMMY;
								cnt_r <= 2'h0;
							end
							OP_PROG: state_r <= ST_PROG;
							default: state_r <= ST_WAIT;
						endcase
					end
				end
				ST_DUMMY: begin
					cnt_r <= cnt_r - 2'h1;
					if (cnt_r == 2'h0) begin
						state_r <= ST_OUT;
					end
				end
				ST_PROG: begin
					data_seen_r <= 1'b1;
					addr_r[7:0] <= addr_r[7:0] + 8'h01;
				end
				ST_STAT: begin
					new_stat_r <= in_byte;
					state_r <= ST_WAIT;
				end
				default: state_r <= state_r;
			endcase
		end else if (fetch && (opc_r == OP_READ || opc_r == OP_FREAD)) begin
			addr_r <= addr_r + 24'h00_0001;
		end
	end

	// ****************************************************************
	// Status bits and job launch
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			busy_r <= 1'b0;
			wel_r <= 1'b0;
			bp_r <= ST_RESET[4:2];
			lock_r <= ST_RESET[7];
			pd_r <= 1'b0;
			JOB_START <= 1'b0;
			JOB_KIND <= JOB_PROG;
			JOB_ADDR <= 24'h00_0000;
		end else begin
			JOB_START <= 1'b0;
			if (busy_r && JOB_DONE) begin
				busy_r <= 1'b0;
				wel_r <= 1'b0;
			end
			if (byte_done && state_r == ST_DUMMY && cnt_r == 2'h0 && opc_r == OP_RELPD) begin
				pd_r <= 1'b0;
			end
			if (commit && state_r == ST_WAIT) begin
				case (opc_r)
					OP_WREN: wel_r <= 1'b1;
					OP_WRDI: wel_r <= 1'b0;
					OP_PDOWN: pd_r <= 1'b1;
					OP_CERASE: begin
						if (wel_r && !prot_any(bp_r, DENSITY_SEL)) begin
							busy_r <= 1'b1;
							JOB_START <= 1'b1;
							JOB_KIND <= JOB_CERASE;
							JOB_ADDR <= 24'h00_0000;
						end
					end
					OP_SERASE: begin
						if (wel_r && !prot_hit(addr_r, bp_r, DENSITY_SEL)) begin
							busy_r <= 1'b1;
							JOB_START <= 1'b1;
							JOB_KIND <= JOB_SERASE;
							JOB_ADDR <= addr_r;
						end
					end
					OP_WRSR: begin
						if (wel_r && !(lock_r && !lnk.guard_n)) begin
							busy_r <= 1'b1;
							JOB_START <= 1'b1;
							JOB_KIND <= JOB_SWRITE;
							JOB_ADDR <= 24'h00_0000;
							bp_r <= new_stat_r[4:2];
							lock_r <= new_stat_r[ST_LOCK_BIT];
						end
					end
					default: busy_r <= busy_r;
				endcase
			end
			if (commit && state_r == ST_PROG && data_seen_r && wel_r) begin
				if (!prot_hit(addr_r, bp_r, DENSITY_SEL)) begin
					busy_r <= 1'b1;
					JOB_START <= 1'b1;
					JOB_KIND <= JOB_PROG;
					JOB_ADDR <= addr_r;
				end
			end
		end
	end

	// ****************************************************************
	// Page data staging
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			DATA_STROBE <= 1'b0;
			DATA_BYTE <= 8'h00;
			DATA_ADDR <= 24'h00_0000;
		end else begin
			DATA_STROBE <= byte_done && (state_r == ST_PROG);
			if (byte_done && state_r == ST_PROG) begin
				DATA_BYTE <= in_byte;
				DATA_ADDR <= addr_r;
			end
		end
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************
	assign out_nxt = (out_cnt_r == 3'h0) ? out_src : osh_r;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N || !lnk.cs_act) begin
			SERIAL_OUT <= 1'b0;
			SERIAL_OUT_OE <= 1'b0;
			out_cnt_r <= 3'h0;
			osh_r <= 8'h00;
			id_sel_r <= 1'b0;
		end else begin
			SERIAL_OUT_OE <= (state_r == ST_OUT);
			if (lnk.sck_fall && state_r == ST_OUT) begin
				SERIAL_OUT <= out_nxt[7];
				osh_r <= {out_nxt[6:0], 1'b0};
				out_cnt_r <= out_cnt_r + 3'h1;
				if (out_cnt_r == 3'h7) begin
					id_sel_r <= ~id_sel_r;
				end
			end
		end
	end

	// ****************************************************************
	// Registered outputs
	// ****************************************************************
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			READ_ADDR <= 24'h00_0000;
			STATUS_BYTE <= ST_RESET;
			POWERED_DOWN <= 1'b0;
		end else begin
			READ_ADDR <= addr_r;
			STATUS_BYTE <= status;
			POWERED_DOWN <= pd_r;
		end
	end
endmodule : sfd_decoder

// ===== sfd_decoder_chk.sv
/*
 * Port-level checks of the serial flash instruction decoder.
 * Assumes the bind below reaches every sfd_decoder instance.
 */
`timescale 1ns/1ns
module sfd_decoder_chk
	import sfd_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Link and jobs
	input wire logic SPI_CS_N,
	input wire logic SERIAL_OUT_OE,
	input wire logic JOB_START,
	input wire logic JOB_DONE,
	// Status
	input wire logic [7:0] STATUS_BYTE,
	input wire logic POWERED_DOWN
);
	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	a_start_needs_latch: assert property (JOB_START |-> $past(STATUS_BYTE[ST_WEL_BIT], 2))
		else $error("job launched with latch clear");
	a_start_when_idle: assert property (JOB_START |-> !$past(STATUS_BYTE[ST_BUSY_BIT], 2))
		else $error("job launched while busy");
	a_busy_follows: assert property (JOB_START |=> ##[0:2] STATUS_BYTE[ST_BUSY_BIT])
		else $error("busy flag not raised");
	a_reserved_zero: assert property (STATUS_BYTE[6:5] == 2'h0)
		else $error("reserved status bits set");
	a_done_clears: assert property (JOB_DONE && STATUS_BYTE[ST_BUSY_BIT]
		|=> ##[0:2] STATUS_BYTE[1:0] == 2'h0)
		else $error("busy or latch kept after done");
	a_jobs_deselected: assert property (JOB_START |-> SPI_CS_N)
		else $error("job launched inside a frame");
	a_idle_quiet: assert property (SPI_CS_N [*8] |-> !SERIAL_OUT_OE)
		else $error("output driven while deselected");
	a_pd_no_job: assert property (POWERED_DOWN |-> !JOB_START)
		else $error("job launched in power-down");
endmodule : sfd_decoder_chk
bind sfd_decoder sfd_decoder_chk u_chk (
	.CORE_CLK(CORE_CLK),
	.RST_N(RST_N),
	.SPI_CS_N(SPI_CS_N),
	.SERIAL_OUT_OE(SERIAL_OUT_OE),
	.JOB_START(JOB_START),
	.JOB_DONE(JOB_DONE),
	.STATUS_BYTE(STATUS_BYTE),
	.POWERED_DOWN(POWERED_DOWN)
);

// ===== sfd_host.sv
/*
 * Serial host model: mode 0 frames at a 160 ns serial clock.
 * Assumes a 20 ns core clock used only for pacing.
 */
`timescale 1ns/1ns
module sfd_host (
	// Pacing clock
	input wire logic clk,
	// Link pins
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so
);
	// ****************************************************************
	// Frame tasks
	// ****************************************************************
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	task automatic half;
		repeat (4) @(negedge clk);
	endtask : half
	task automatic sel;
		cs_n = 1'b0;
		half();
	endtask : sel
	task automatic xbit(input logic b, output logic r);
		si = b;
		half();
		sck = 1'b1;
		half();
		r = so;
		sck = 1'b0;
	endtask : xbit
	task automatic xbyte(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			xbit(d[i], q[i]);
		end
	endtask : xbyte
	task automatic desel;
		half();
		cs_n = 1'b1;
		si = ~si;
		repeat (3) half();
	endtask : desel
endmodule : sfd_host

// ===== sfd_link_if.sv
/*
 * Synchronised view of the serial link pins, passed from the pin
 * synchroniser to the decoder. Assumes one core clock on both ends.
 */
`timescale 1ns/1ns
interface sfd_link_if;
	logic cs_act;
	logic cs_rise;
	logic sck_rise;
	logic sck_fall;
	logic si;
	logic guard_n;
	modport src (output cs_act, cs_rise, sck_rise, sck_fall, si, guard_n);
	modport dst (input cs_act, cs_rise, sck_rise, sck_fall, si, guard_n);
endinterface : sfd_link_if

// ===== sfd_link_sync.sv
/*
 * Two-flop synchronisers for the link pins and edge detection of the
 * serial clock and select. Assumes the pins are asynchronous to clk.
 */
`timescale 1ns/1ns
module sfd_link_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Raw pins
	input wire logic cs_n_pin,
	input wire logic sck_pin,
	input wire logic si_pin,
	input wire logic guard_n_pin,
	// Synchronised link
	sfd_link_if.src lnk
);
	logic [3:0] meta_r;
	logic [3:0] sync_r;
	logic sck_d_r;
	logic cs_n_d_r;

	// ****************************************************************
	// Synchronisers and edge history
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= 4'hF;
			sync_r <= 4'hF;
			sck_d_r <= 1'b0;
			cs_n_d_r <= 1'b1;
		end else begin
			meta_r <= {guard_n_pin, si_pin, sck_pin, cs_n_pin};
			sync_r <= meta_r;
			sck_d_r <= sync_r[1];
			cs_n_d_r <= sync_r[0];
		end
	end

	assign lnk.cs_act = ~sync_r[0];
	assign lnk.cs_rise = sync_r[0] & ~cs_n_d_r;
	assign lnk.sck_rise = ~sync_r[0] & sync_r[1] & ~sck_d_r;
	assign lnk.sck_fall = ~sync_r[0] & ~sync_r[1] & sck_d_r;
	assign lnk.si = sync_r[2];
	assign lnk.guard_n = sync_r[3];
endmodule : sfd_link_sync

// ===== sfd_pkg.sv
/*
 * Constants of the serial flash instruction decoder: opcodes, status bit
 * positions, protection boundaries, variant codes and array job kinds.
 * Assumes nothing of its surroundings.
 */
package sfd_pkg;
	// ****************************************************************
	// Opcodes
	// ****************************************************************
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_WRSR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FREAD = 8'h0B;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_SERASE = 8'hD8;
	localparam logic [7:0] OP_CERASE = 8'hC7;
	localparam logic [7:0] OP_PDOWN = 8'hB9;
	localparam logic [7:0] OP_RELPD = 8'hAB;
	localparam logic [7:0] OP_MFID = 8'h90;
	// ****************************************************************
	// Status byte layout and reset value
	// ****************************************************************
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_BP_LSB = 2;
	localparam int ST_LOCK_BIT = 7;
	localparam logic [7:0] ST_WRITABLE = 8'h9C;
	localparam logic [7:0] ST_RESET = 8'h00;
	// ****************************************************************
	// Density variants and protection boundaries
	// ****************************************************************
	localparam logic [1:0] DENS_1M = 2'h0;
	localparam logic [1:0] DENS_2M = 2'h1;
	localparam logic [1:0] DENS_4M = 2'h2;
	localparam logic [23:0] P4_EIGHTH = 24'h07_0000;
	localparam logic [23:0] P4_QUARTER = 24'h06_0000;
	localparam logic [23:0] P4_HALF = 24'h04_0000;
	localparam logic [23:0] P4_TOP = 24'h07_FFFF;
	localparam logic [23:0] P2_QUARTER = 24'h03_0000;
	localparam logic [23:0] P2_HALF = 24'h02_0000;
	localparam logic [23:0] P2_TOP = 24'h03_FFFF;
	localparam logic [23:0] P1_TOP = 24'h01_FFFF;
	// ****************************************************************
	// Identification codes (values are arbitrary)
	// ****************************************************************
	localparam logic [7:0] MAKER_CODE = 8'h5A;
	localparam logic [7:0] PART_CODE_1M = 8'hA1;
	localparam logic [7:0] PART_CODE_2M = 8'hA2;
	localparam logic [7:0] PART_CODE_4M = 8'hA3;
	// ****************************************************************
	// Array job kinds and frame byte counts
	// ****************************************************************
	localparam logic [1:0] JOB_PROG = 2'h0;
	localparam logic [1:0] JOB_SERASE = 2'h1;
	localparam logic [1:0] JOB_CERASE = 2'h2;
	localparam logic [1:0] JOB_SWRITE = 2'h3;
	localparam logic [1:0] ADDR_BYTES_LEFT = 2'h2;
	localparam logic [1:0] DUMMY_BYTES_LEFT = 2'h2;
endpackage : sfd_pkg

// ===== tb.sv
/*
 * Self-checking bench of the decoder with a host model and array stub.
 * Assumes a 50 MHz core clock and a fixed random seed.
 */
`timescale 1ns/1ns
module tb;
	import sfd_pkg::*;
	logic CORE_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic WRITE_GUARD_N = 1'b1;
	logic JOB_DONE = 1'b0;
	logic [1:0] DENSITY_SEL = DENS_4M;
	logic SPI_CS_N, SPI_SCK, SERIAL_IN, SERIAL_OUT, SERIAL_OUT_OE;
	logic JOB_START, DATA_STROBE, POWERED_DOWN, ok;
	logic [1:0] JOB_KIND, kind;
	logic [23:0] JOB_ADDR, DATA_ADDR, READ_ADDR, daddr, jaddr, a;
	logic [7:0] DATA_BYTE, ARRAY_RDATA, STATUS_BYTE, rd, dbyte;
	int bad_count = 0;
	int checked = 0;
	int jobs = 0;
	int seed = 31;
	int n;
	// ****************************************************************
	// Array stub, monitor and helpers
	// ****************************************************************
	function automatic logic [7:0] arr(input logic [23:0] x);
		return x[7:0] ^ x[15:8] ^ 8'h5C;
	endfunction : arr
	function automatic logic prot(input logic [1:0] d, input logic [2:0] b, input logic [23:0] x);
		case (d)
			DENS_4M: return b[2] || (b[1:0] == 2'h3 && x >= P4_HALF)
				|| (b[1:0] == 2'h2 && x >= P4_QUARTER) || (b[1:0] == 2'h1 && x >= P4_EIGHTH);
			DENS_2M: return b[1:0] == 2'h3 || (b[1:0] == 2'h2 && x >= P2_HALF)
				|| (b[1:0] == 2'h1 && x >= P2_QUARTER);
			default: return b[1:0] == 2'h3;
		endcase
	endfunction : prot
	always #10 CORE_CLK = ~CORE_CLK;
	assign ARRAY_RDATA = arr(READ_ADDR);
	always @(posedge CORE_CLK) begin
		if (JOB_START) begin
			jobs++;
			kind = JOB_KIND;
			jaddr = JOB_ADDR;
		end
		if (DATA_STROBE) begin
			dbyte = DATA_BYTE;
			daddr = DATA_ADDR;
		end
	end
	sfd_decoder u_sfd_decoder (
		.CORE_CLK(CORE_CLK),
		.RST_N(RST_N),
		.SPI_CS_N(SPI_CS_N),
		.SPI_SCK(SPI_SCK),
		.SERIAL_IN(SERIAL_IN),
		.SERIAL_OUT(SERIAL_OUT),
		.SERIAL_OUT_OE(SERIAL_OUT_OE),
		.WRITE_GUARD_N(WRITE_GUARD_N),
		.DENSITY_SEL(DENSITY_SEL),
		.JOB_START(JOB_START),
		.JOB_KIND(JOB_KIND),
		.JOB_ADDR(JOB_ADDR),
		.JOB_DONE(JOB_DONE),
		.DATA_STROBE(DATA_STROBE),
		.DATA_BYTE(DATA_BYTE),
		.DATA_ADDR(DATA_ADDR),
		.READ_ADDR(READ_ADDR),
		.ARRAY_RDATA(ARRAY_RDATA),
		.STATUS_BYTE(STATUS_BYTE),
		.POWERED_DOWN(POWERED_DOWN)
	);
	sfd_host u_sfd_host (
		.clk(CORE_CLK),
		.cs_n(SPI_CS_N),
		.sck(SPI_SCK),
		.si(SERIAL_IN),
		.so(SERIAL_OUT)
	);
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("checks=%0d mismatches=%0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report
	task automatic pre(input logic [7:0] q[$]);
		u_sfd_host.sel();
		foreach (q[i]) u_sfd_host.xbyte(q[i], rd);
	endtask : pre
	task automatic cmd(input logic [7:0] q[$]);
		pre(q);
		u_sfd_host.desel();
	endtask : cmd
	task automatic done;
		JOB_DONE = 1'b1;
		@(negedge CORE_CLK);
		JOB_DONE = 1'b0;
		repeat (4) @(negedge CORE_CLK);
	endtask : done
	task automatic wjob(input logic [7:0] q[$], input logic exp, input logic fin);
		n = jobs;
		cmd(q);
		chk(jobs - n, exp);
		if (fin && jobs != n) begin
			done();
		end
	endtask : wjob
	task automatic rdsr(input logic [7:0] exp);
		pre('{OP_RDSR});
		u_sfd_host.xbyte(8'h00, rd);
		chk(rd, exp);
		chk(SERIAL_OUT_OE, 1'b1);
		u_sfd_host.xbyte(8'h00, rd);
		chk(rd, exp);
		u_sfd_host.desel();
	endtask : rdsr
	// ****************************************************************
	// Tests
	// ****************************************************************
	initial begin
		#1_200_000;
		bad_count++;
		final_report();
	end
	initial begin
		repeat (6) @(negedge CORE_CLK);
		RST_N = 1'b1;
		repeat (4) @(negedge CORE_CLK);
		chk(STATUS_BYTE, ST_RESET);
		rdsr(ST_RESET);
		cmd('{OP_WREN});
		rdsr(8'h02);
		cmd('{OP_WRDI});
		rdsr(8'h00);
		wjob('{OP_PROG, 8'h00, 8'h10, 8'h00, 8'h11}, 1'b0, 1'b1);
		$display("latch test done");
		for (int d = 0; d < 3; d++) begin
			for (int bp = 0; bp < 8; bp++) begin
				DENSITY_SEL = d[1:0];
				cmd('{OP_WREN});
				wjob('{OP_WRSR, {3'h0, bp[2:0], 2'h0}}, 1'b1, 1'b1);
				rdsr({3'h0, bp[2:0], 2'h0});
				a = $random(seed) & (d == 2 ? P4_TOP : d == 1 ? P2_TOP : P1_TOP);
				if (d == 2 && bp == 2) a = P4_QUARTER;
				if (d == 1 && bp == 2) a = P2_HALF - 24'h00_0001;
				ok = !prot(d[1:0], bp[2:0], a);
				cmd('{OP_WREN});
				wjob('{OP_PROG, a[23:16], a[15:8], a[7:0], 8'hA5}, ok, 1'b1);
				if (ok) begin
					chk({kind, dbyte, daddr}, {JOB_PROG, 8'hA5, a});
				end else begin
					cmd('{OP_WRDI});
				end
			end
		end
		$display("protection test done");
		DENSITY_SEL = DENS_4M;
		cmd('{OP_WREN});
		wjob('{OP_WRSR, 8'h00}, 1'b1, 1'b1);
		cmd('{OP_WREN});
		wjob('{OP_PROG, 8'h01, 8'h02, 8'h03, 8'h44}, 1'b1, 1'b0);
		cmd('{OP_WRDI});
		wjob('{OP_CERASE}, 1'b0, 1'b0);
		rdsr(8'h03);
		done();
		rdsr(8'h00);
		$display("busy test done");
		cmd('{OP_WREN});
		n = jobs;
		pre('{OP_SERASE, 8'h05, 8'h00});
		u_sfd_host.xbit(1'b0, rd[0]);
		u_sfd_host.desel();
		chk(jobs - n, 0);
		wjob('{OP_SERASE, 8'h05, 8'h00, 8'h00}, 1'b1, 1'b1);
		chk({kind, jaddr}, {JOB_SERASE, 24'h05_0000});
		cmd('{OP_WREN});
		wjob('{OP_CERASE}, 1'b1, 1'b1);
		chk(kind, JOB_CERASE);
		$display("erase test done");
		cmd('{OP_WREN});
		wjob('{OP_WRSR, 8'h80}, 1'b1, 1'b1);
		chk(kind, JOB_SWRITE);
		WRITE_GUARD_N = 1'b0;
		cmd('{OP_WREN});
		wjob('{OP_WRSR, 8'h00}, 1'b0, 1'b1);
		rdsr(8'h82);
		WRITE_GUARD_N = 1'b1;
		wjob('{OP_WRSR, 8'h00}, 1'b1, 1'b1);
		rdsr(8'h00);
		$display("lock test done");
		a = $random(seed) & P4_TOP;
		for (int f = 0; f < 2; f++) begin
			pre('{f ? OP_FREAD : OP_READ, a[23:16], a[15:8], a[7:0]});
			if (f) u_sfd_host.xbyte(8'h00, rd);
			u_sfd_host.xbyte(8'h00, rd);
			chk(rd, arr(a));
			u_sfd_host.xbyte(8'h00, rd);
			chk(rd, arr(a + 24'h00_0001));
			u_sfd_host.xbit(1'b0, rd[0]);
			u_sfd_host.desel();
		end
		rdsr(8'h00);
		pre('{OP_MFID, 8'h00, 8'h00, 8'h00});
		for (int i = 0; i < 3; i++) begin
			u_sfd_host.xbyte(8'h00, rd);
			chk(rd, i[0] ? PART_CODE_4M : MAKER_CODE);
		end
		u_sfd_host.desel();
		cmd('{OP_PDOWN});
		chk(POWERED_DOWN, 1'b1);
		cmd('{OP_WREN});
		pre('{OP_RELPD, 8'h00, 8'h00, 8'h00});
		for (int i = 0; i < 2; i++) begin
			u_sfd_host.xbyte(8'h00, rd);
			chk(rd, PART_CODE_4M);
		end
		u_sfd_host.desel();
		chk(POWERED_DOWN, 1'b0);
		rdsr(8'h00);
		$display("read and id test done");
		final_report();
	end
endmodule : tb
